// file: include/port_link_if.sv
// link between the cache-side arbiter and its storage ports
`timescale 1ns/1ps
interface port_link_if;
  import storage_port_pkg::*;
  logic [NUM_PORTS-1:0] port_request;
  logic [NUM_PORTS-1:0] select_address_strobe;
  logic [NUM_PORTS-1:0] select_data_strobe;
  logic [NUM_PORTS-1:0] port_data_ready;
  logic request_accepted;
  logic address_accepted;
  logic port_timeout;
  // per-port copies of the shared lines; a port drives zero while unselected
  addr_t port_addr [NUM_PORTS];
  op_t port_op [NUM_PORTS];
  data_t port_wdata [NUM_PORTS];
  data_t mem_data;

  modport cache_mp (
    input port_request, port_addr, port_op, port_wdata,
    output select_address_strobe, select_data_strobe, port_data_ready,
    output request_accepted, address_accepted, port_timeout, mem_data
  );
  modport port_mp (
    output port_request, port_addr, port_op, port_wdata,
    input select_address_strobe, select_data_strobe, port_data_ready,
    input request_accepted, address_accepted, port_timeout, mem_data
  );
endinterface : port_link_if

// file: include/storage_port_pkg.sv
// shared constants, types and decode helpers for the storage-port memory link
package storage_port_pkg;
  // link geometry
  localparam int NUM_PORTS = 4;
  localparam int PORT_ID_W = 2;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int OP_W = 3;
  // address split for the tag store lookup
  localparam int INDEX_LSB = 2;
  localparam int INDEX_MSB = 9;
  localparam int INDEX_W = INDEX_MSB - INDEX_LSB + 1;
  localparam int TAG_LSB = 10;
  localparam int TAG_MSB = 21;
  localparam int TAG_W = TAG_MSB - TAG_LSB + 1;
  // operation codes, bit order {operation_code_bits}
  localparam logic [OP_W-1:0] OP_READ_DW = 3'h0;
  localparam logic [OP_W-1:0] OP_READ_DW_ALT = 3'h2;
  localparam logic [OP_W-1:0] OP_WRITE_WORD = 3'h4;
  localparam logic [OP_W-1:0] OP_WRITE_DW = 3'h5;
  localparam logic [OP_W-1:0] OP_WRITE_BYTE = 3'h6;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MEM_TIMEOUT_NS = 2560;
  localparam int MEM_TIMEOUT_CYCLES = MEM_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int OWNER_FIFO_DEPTH = 16;
  // reset values
  localparam logic [NUM_PORTS-1:0] STROBES_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [OP_W-1:0] op_t;

  // operations with c1 low fetch data from memory
  function automatic logic op_is_read(input op_t op);
    return (op[2] == 1'b0);
  endfunction : op_is_read
endpackage : storage_port_pkg

// file: sim/port_link_properties.sv
// concurrent checks on the link between the arbiter and its storage ports
`timescale 1ns/1ps
module port_link_properties
  import storage_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [storage_port_pkg::NUM_PORTS-1:0] port_request,
  input wire logic [storage_port_pkg::NUM_PORTS-1:0] select_address_strobe,
  input wire logic [storage_port_pkg::NUM_PORTS-1:0] select_data_strobe,
  input wire logic [storage_port_pkg::NUM_PORTS-1:0] port_data_ready,
  input wire logic request_accepted,
  input wire logic address_accepted,
  input wire logic port_timeout,
  input wire storage_port_pkg::data_t mem_data
);
  import storage_port_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // address phase: the same winner held for exactly two cycles
  sequence s_select;
    $rose(|select_address_strobe) ##1 $stable(select_address_strobe);
  endsequence
  // then the data select to that winner alone, then the accept pulse
  sequence s_handoff;
    ##1 (select_address_strobe == 4'h0 && select_data_strobe == $past(select_address_strobe, 2))
    ##1 (request_accepted && select_data_strobe == 4'h0);
  endsequence
  chk_select_one_port: assert property ($onehot0(select_address_strobe))
    else $error("more than one port selected");
  chk_fixed_priority: assert property ($rose(|select_address_strobe) |->
    select_address_strobe == ($past(port_request) & (~$past(port_request) + 4'h1)))
    else $error("winner is not the lowest requesting port");
  chk_handshake_order: assert property (s_select |-> s_handoff)
    else $error("select and accept steps out of order");
  chk_request_dropped: assert property (request_accepted |=>
    (port_request & $past(select_data_strobe, 2)) == 4'h0)
    else $error("served port kept its request");
  chk_request_held: assert property ((|($past(port_request) & ~port_request)) |->
    $past(request_accepted))
    else $error("request dropped before accept");
  chk_memory_answer: assert property (request_accepted |->
    ##[2:40] (address_accepted || port_timeout))
    else $error("no memory answer after accept");
  chk_answer_exclusive: assert property (!(address_accepted && port_timeout))
    else $error("accept and timeout together");
  chk_ready_one_port: assert property ($onehot0(port_data_ready))
    else $error("data ready to several ports");
  chk_data_held: assert property (port_data_ready == 4'h0 |-> $stable(mem_data))
    else $error("returned data changed without ready");
endmodule : port_link_properties

// file: sim/storage_port_memory_arbiter_tb.sv
// self-checking bench: arbiter and four storage ports joined by one link
`timescale 1ns/1ps
module storage_port_memory_arbiter_tb;
  import storage_port_pkg::*;
  localparam int TMO = 8; // short memory timeout keeps the run brief
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic mem_req, mem_write, mem_ack, mem_data_valid, tag_lookup, tag_valid, tag_invalidate;
  op_t mem_op;
  addr_t mem_addr, cur_addr, cap_addr;
  data_t mem_wdata, mem_rdata, cap_wdata;
  op_t cap_op;
  logic cap_write, ack_on, ret_on, tag_hit, inval_seen, tmo_seen, wdrv_seen;
  logic [INDEX_W-1:0] tag_index, cap_index;
  logic [TAG_W-1:0] tag_stored;
  logic [NUM_PORTS-1:0] cmd_valid, cmd_ready, done, done_error, ready_seen, sel_prev;
  op_t cmd_op [NUM_PORTS];
  addr_t cmd_addr [NUM_PORTS];
  data_t cmd_wdata [NUM_PORTS];
  data_t rd_data [NUM_PORTS];
  logic [NUM_PORTS-1:0] sel_order [$];
  logic [NUM_PORTS-1:0] ready_order [$];
  addr_t ret_q [$];
  int bad_count = 0;
  int samples_checked = 0;

  port_link_if link ();
  storage_port_memory_arbiter #(.TIMEOUT_CYCLES(TMO), .FIFO_DEPTH(16)) i_storage_port_memory_arbiter (
    .core_clk(core_clk), .rst(rst), .link(link.cache_mp), .mem_req(mem_req), .mem_write(mem_write),
    .mem_op(mem_op), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_data_valid(mem_data_valid), .mem_rdata(mem_rdata), .tag_lookup(tag_lookup), .tag_index(tag_index),
    .tag_stored(tag_stored), .tag_valid(tag_valid), .tag_invalidate(tag_invalidate));
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    storage_port_end #(.PORT_ID(g)) i_storage_port_end (.core_clk(core_clk), .rst(rst), .link(link.port_mp),
      .cmd_valid(cmd_valid[g]), .cmd_ready(cmd_ready[g]), .cmd_op(cmd_op[g]), .cmd_addr(cmd_addr[g]),
      .cmd_wdata(cmd_wdata[g]), .done(done[g]), .done_error(done_error[g]), .rd_data(rd_data[g]));
  end
  port_link_properties i_port_link_properties (.core_clk(core_clk), .rst(rst),
    .port_request(link.port_request), .select_address_strobe(link.select_address_strobe),
    .select_data_strobe(link.select_data_strobe), .port_data_ready(link.port_data_ready),
    .request_accepted(link.request_accepted), .address_accepted(link.address_accepted),
    .port_timeout(link.port_timeout), .mem_data(link.mem_data));

  always #5 core_clk = ~core_clk;

  // memory and tag store model; data waits until the owner push has landed, else it would be dropped
  always @(posedge core_clk) begin
    mem_ack <= ack_on && mem_req && !mem_ack;
    mem_data_valid <= 1'b0;
    if (ret_on && !mem_data_valid && !mem_ack && !link.address_accepted && ret_q.size() > 0) begin
      mem_data_valid <= 1'b1;
      mem_rdata <= {ret_q.pop_front(), 10'h155};
    end
    if (ack_on && mem_req && !mem_ack) begin
      cap_addr <= mem_addr;
      cap_op <= mem_op;
      cap_wdata <= mem_wdata;
      cap_write <= mem_write;
      if (!mem_write) ret_q.push_back(mem_addr);
    end
    if (tag_lookup) begin
      tag_stored <= cur_addr[TAG_MSB:TAG_LSB] ^ {11'h0, !tag_hit}; // a miss differs in the lowest tag bit only
      tag_valid <= 1'b1;
      cap_index <= tag_index;
    end
    inval_seen <= inval_seen | tag_invalidate;
    tmo_seen <= tmo_seen | link.port_timeout;
    // any port putting write data on its lines, readers must never do so
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (link.port_wdata[i] != 32'h0) begin
        wdrv_seen <= 1'b1;
      end
    end
    ready_seen <= ready_seen | link.port_data_ready;
    if (link.select_address_strobe != 4'h0 && sel_prev == 4'h0) sel_order.push_back(link.select_address_strobe);
    sel_prev <= link.select_address_strobe;
    if (link.port_data_ready != 4'h0) ready_order.push_back(link.port_data_ready);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // hold the command until the edge where ready is sampled high
  task automatic issue(input int p, input op_t op, input addr_t a, input data_t wd);
    int n = 0;
    @(posedge core_clk);
    cmd_valid[p] <= 1'b1;
    cmd_op[p] <= op;
    cmd_addr[p] <= a;
    cmd_wdata[p] <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready[p] !== 1'b1 && n < 100);
    cmd_valid[p] <= 1'b0;
  endtask : issue

  task automatic wait_done(input int p);
    int n = 0;
    while (done[p] !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    check("done", done[p], 1'b1);
  endtask : wait_done

  task automatic do_op(input int p, input op_t op, input addr_t a, input data_t wd, input logic hit,
                       input logic err);
    cur_addr = a;
    tag_hit = hit;
    inval_seen = 1'b0;
    tmo_seen = 1'b0;
    wdrv_seen = 1'b0;
    ready_seen = 4'h0;
    issue(p, op, a, wd);
    wait_done(p);
    check("done_error", done_error[p], err);
    check("timeout", tmo_seen, err);
    check("index", cap_index, a[INDEX_MSB:INDEX_LSB]);
    check("ready", ready_seen, op[2] ? 4'h0 : 4'h1 << p);
    check("wdata_drive", wdrv_seen, op[2]);
    if (!err) begin
      check("address", cap_addr, a);
      check("op", cap_op, op);
      check("write", cap_write, op[2]);
      check("invalidate", inval_seen, hit && op[2]);
      if (op[2]) check("wdata", cap_wdata, wd);
      else check("rd_data", rd_data[p], {a, 10'h155});
    end
  endtask : do_op

  // every operation code, hit and miss, on all four ports
  task automatic t_codes();
    op_t codes [5] = '{OP_READ_DW, OP_READ_DW_ALT, OP_WRITE_WORD, OP_WRITE_DW, OP_WRITE_BYTE};
    for (int i = 0; i < 10; i++) begin
      do_op(i % 4, codes[i % 5], 22'h2aa554 + 22'(i * 22'h1004), 32'hc0de_0000 + 32'(i), i[0], 1'b0);
    end
    $display("test codes done");
  endtask : t_codes

  // four reads at once with memory data held back: order of service and of return
  task automatic t_priority();
    int n = 0;
    sel_order.delete();
    ready_order.delete();
    ret_on = 1'b0;
    tag_hit = 1'b0;
    fork
      issue(3, OP_READ_DW, 22'h3ffffc, 32'h0);
      issue(2, OP_READ_DW, 22'h000000, 32'h0);
      issue(1, OP_READ_DW, 22'h155554, 32'h0);
      issue(0, OP_READ_DW, 22'h2aaaa8, 32'h0);
    join
    while (sel_order.size() < 4 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    ret_on = 1'b1;
    for (int p = 0; p < 4; p++) wait_done(p);
    for (int p = 0; p < 4; p++) begin
      check("served", sel_order[p], 4'h1 << p);
      check("returned", ready_order[p], 4'h1 << p);
    end
    check("rd_data3", rd_data[3], {22'h3ffffc, 10'h155});
    check("rd_data0", rd_data[0], {22'h2aaaa8, 10'h155});
    $display("test priority done");
  endtask : t_priority

  // memory never answers, then a normal read shows the link recovered
  task automatic t_timeout();
    ack_on = 1'b0;
    do_op(2, OP_WRITE_WORD, 22'h0abcd4, 32'h1234_5678, 1'b0, 1'b1);
    ack_on = 1'b1;
    do_op(2, OP_READ_DW, 22'h0abcd8, 32'h0, 1'b1, 1'b0);
    $display("test timeout done");
  endtask : t_timeout

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    {mem_ack, mem_data_valid, tag_valid, inval_seen, tmo_seen, tag_hit, wdrv_seen} = 7'h0;
    {ack_on, ret_on} = 2'h3;
    mem_rdata = 32'h0;
    tag_stored = 12'h0;
    cmd_valid = 4'h0;
    sel_prev = 4'h0;
    foreach (cmd_op[i]) begin
      cmd_op[i] = 3'h0;
      cmd_addr[i] = 22'h0;
      cmd_wdata[i] = 32'h0;
    end
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_codes();
    t_priority();
    t_timeout();
    stop_test();
  end

  // the tests need a few hundred cycles; this allows 20000 cycles
  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : storage_port_memory_arbiter_tb

// file: src/storage_port_end.sv
// one storage port: requests memory transfers from the cache-side arbiter
`timescale 1ns/1ps
module storage_port_end
  import storage_port_pkg::*;
#(
  parameter int PORT_ID = 0
) (
  input wire logic core_clk,
  input wire logic rst,
  port_link_if.port_mp link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire storage_port_pkg::op_t cmd_op,
  input wire storage_port_pkg::addr_t cmd_addr,
  input wire storage_port_pkg::data_t cmd_wdata,
  output logic done,
  output logic done_error,
  output storage_port_pkg::data_t rd_data
);
  import storage_port_pkg::*;

  // each port owns one bit of the shared strobe vectors
  if (PORT_ID < 0 || PORT_ID >= NUM_PORTS) begin : g_bad_port_id
    $error("storage_port_end: port id out of range");
  end

  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_REQ = 4'b0010,
    P_ADDR = 4'b0100,
    P_DATA = 4'b1000
  } port_state_t;

  port_state_t state_q;
  port_state_t state_d;
  op_t op_q;
  addr_t addr_q;
  data_t wdata_q;
  logic req_q;
  logic selected_q;
  addr_t addr_drv_q;
  op_t op_drv_q;
  data_t wdata_drv_q;
  logic cmd_ready_q;
  logic done_q;
  logic done_err_q;
  data_t rd_data_q;
  logic accepted;

  assign accepted = link.request_accepted && selected_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      P_IDLE: begin
        if (cmd_valid && cmd_ready_q) begin
          state_d = P_REQ;
        end
      end
      P_REQ: begin
        if (accepted) begin
          state_d = P_ADDR;
        end
      end
      P_ADDR: begin
        if (link.port_timeout) begin
          state_d = P_IDLE;
        end else if (link.address_accepted) begin
          state_d = op_is_read(op_q) ? P_DATA : P_IDLE;
        end
      end
      P_DATA: begin
        if (link.port_data_ready[PORT_ID]) begin
          state_d = P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= P_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request line held from command until the arbiter accepts it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_q <= 1'b0;
      op_q <= OP_READ_DW;
      addr_q <= ADDR_RESET;
      wdata_q <= DATA_RESET;
      cmd_ready_q <= 1'b0;
    end else begin
      cmd_ready_q <= (state_d == P_IDLE);
      if (state_q == P_IDLE && cmd_valid && cmd_ready_q) begin
        op_q <= cmd_op;
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
      end
      req_q <= (state_d == P_REQ);
    end
  end

  // shared lines driven only while selected, released once accepted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      selected_q <= 1'b0;
      addr_drv_q <= ADDR_RESET;
      op_drv_q <= OP_READ_DW;
      wdata_drv_q <= DATA_RESET;
    end else if (state_q != P_REQ || accepted) begin
      selected_q <= 1'b0;
      addr_drv_q <= ADDR_RESET; // free to change after acceptance
      op_drv_q <= OP_READ_DW;
      wdata_drv_q <= DATA_RESET;
    end else begin
      if (link.select_address_strobe[PORT_ID]) begin
        selected_q <= 1'b1;
        addr_drv_q <= addr_q;
        op_drv_q <= op_q;
      end
      // a reader leaves the data lines alone
      if (link.select_data_strobe[PORT_ID] && !op_is_read(op_q)) begin
        wdata_drv_q <= wdata_q;
      end
    end
  end

  // completion toward the user side
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_q <= 1'b0;
      done_err_q <= 1'b0;
      rd_data_q <= DATA_RESET;
    end else begin
      done_q <= (state_q == P_ADDR && (link.port_timeout || (link.address_accepted && !op_is_read(op_q))))
                || (state_q == P_DATA && link.port_data_ready[PORT_ID]);
      done_err_q <= (state_q == P_ADDR) && link.port_timeout;
      if (state_q == P_DATA && link.port_data_ready[PORT_ID]) begin
        rd_data_q <= link.mem_data;
      end
    end
  end

  assign link.port_request[PORT_ID] = req_q;
  assign link.port_addr[PORT_ID] = addr_drv_q;
  assign link.port_op[PORT_ID] = op_drv_q;
  assign link.port_wdata[PORT_ID] = wdata_drv_q;
  assign cmd_ready = cmd_ready_q;
  assign done = done_q;
  assign done_error = done_err_q;
  assign rd_data = rd_data_q;
endmodule : storage_port_end

// file: src/storage_port_memory_arbiter.sv
// cache-side arbiter that runs uncached memory cycles for up to four storage ports
//
// Overview of operation
// - every port access runs a memory cycle
// - port data never touches fast data memory
// - port holds request until it is accepted
// - pick exactly one of four requesting ports
// - strobe winner's select address; it drives address
// - latch address and opcode when cycle starts
// - select data strobe; writer drives write data
// - request accepted; port drops request, frees address
// - memory acknowledge becomes address accepted
// - address accepted ends a write transaction
// - forward returned double word to reader
// - data ready strobe only to reading port
// - remember owner of outstanding reads
// - port presents 22-bit address, bits 21..0
// - index tag store with address bits 9..2
// - compare address bits 21..10 for hit
// - write hit invalidates the cached entry
// - reader ignores select data strobe
// - data ready loads data, ends read
// - memory timeout raises port timeout
`timescale 1ns/1ps

// small synchronous fifo; here it keeps read owners in issue order
module owner_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointers wrap by overflow, so only power-of-two depths are served
  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_geometry
    $error("owner_fifo: width must be positive and depth a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage array, no reset needed on the data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule : owner_fifo

module storage_port_memory_arbiter
  import storage_port_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = storage_port_pkg::MEM_TIMEOUT_CYCLES,
  parameter int FIFO_DEPTH = storage_port_pkg::OWNER_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  port_link_if.cache_mp link,
  // main memory bus, sequenced by the cache
  output logic mem_req,
  output logic mem_write,
  output storage_port_pkg::op_t mem_op,
  output storage_port_pkg::addr_t mem_addr,
  output storage_port_pkg::data_t mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_data_valid,
  input wire storage_port_pkg::data_t mem_rdata,
  // tag store: answer is valid the cycle after a lookup
  output logic tag_lookup,
  output logic [storage_port_pkg::INDEX_W-1:0] tag_index,
  input wire logic [storage_port_pkg::TAG_W-1:0] tag_stored,
  input wire logic tag_valid,
  output logic tag_invalidate
);
  import storage_port_pkg::*;

  // the wait counter is 16 bits wide and needs at least two cycles to count
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin : g_bad_timeout
    $error("storage_port_memory_arbiter: timeout out of range");
  end

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADRS = 6'b000010,
    S_LATCH = 6'b000100,
    S_DATA = 6'b001000,
    S_ACK = 6'b010000,
    S_MEM = 6'b100000
  } arb_state_t;

  arb_state_t state_q;
  arb_state_t state_d;
  logic [PORT_ID_W-1:0] grant_q;
  logic [PORT_ID_W-1:0] winner;
  logic [NUM_PORTS-1:0] sel_adrs_q;
  logic [NUM_PORTS-1:0] sel_data_q;
  logic [NUM_PORTS-1:0] data_rdy_q;
  logic req_ack_q;
  logic address_accepted_q;
  logic timeout_q;
  data_t mem_data_q;
  addr_t addr_q;
  op_t op_q;
  logic mem_write_q;
  data_t wdata_q;
  logic mem_req_q;
  logic tag_lookup_q;
  logic inval_q;
  logic [15:0] wait_cnt_q;
  logic mem_done;
  logic mem_expired;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [PORT_ID_W-1:0] fifo_owner;
  logic write_hit;

  // lowest-numbered requester wins; deterministic, no fairness
  function automatic logic [PORT_ID_W-1:0] pick_port(input logic [NUM_PORTS-1:0] req);
    logic [PORT_ID_W-1:0] id;
    id = '0;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (req[i]) begin
        id = PORT_ID_W'(i);
      end
    end
    return id;
  endfunction : pick_port

  function automatic logic [NUM_PORTS-1:0] one_hot(input logic [PORT_ID_W-1:0] id);
    return NUM_PORTS'(1) << id;
  endfunction : one_hot

  assign winner = pick_port(link.port_request);
  assign mem_done = (state_q == S_MEM) && mem_ack;
  assign mem_expired = (state_q == S_MEM) && !mem_ack && (wait_cnt_q == 16'(TIMEOUT_CYCLES - 1));
  // tag answer arrives during S_ACK; only a valid matching line can go stale
  assign write_hit = !op_is_read(op_q) && tag_valid && (tag_stored == addr_q[TAG_MSB:TAG_LSB]);

  // sequence: select address, latch, select data, accept, memory cycle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        // a full owner queue stalls new work rather than lose a read owner
        if (|link.port_request && fifo_in_ready) begin
          state_d = S_ADRS;
        end
      end
      S_ADRS: begin
        state_d = S_LATCH;
      end
      S_LATCH: begin
        state_d = S_DATA;
      end
      S_DATA: begin
        state_d = S_ACK;
      end
      S_ACK: begin
        state_d = S_MEM; // hit or miss alike
      end
      S_MEM: begin
        if (mem_done || mem_expired) begin
          state_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // port selection strobes, decoded from the next state so they leave flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      grant_q <= '0;
      sel_adrs_q <= STROBES_RESET;
      sel_data_q <= STROBES_RESET;
      req_ack_q <= 1'b0;
    end else begin
      if (state_q == S_IDLE) begin
        grant_q <= winner;
      end
      sel_adrs_q <= (state_d == S_ADRS || state_d == S_LATCH) ?
                    one_hot((state_q == S_IDLE) ? winner : grant_q) : STROBES_RESET;
      sel_data_q <= (state_d == S_DATA) ? one_hot(grant_q) : STROBES_RESET;
      req_ack_q <= (state_d == S_ACK);
    end
  end

  // holding registers for the selected port's request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_q <= ADDR_RESET;
      op_q <= OP_READ_DW;
      mem_write_q <= 1'b0;
      wdata_q <= DATA_RESET;
    end else begin
      if (state_q == S_LATCH) begin
        addr_q <= link.port_addr[grant_q];
        op_q <= link.port_op[grant_q];
        mem_write_q <= !op_is_read(link.port_op[grant_q]); // decoded here so the pin leaves a flop
      end
      if (state_q == S_ACK && !op_is_read(op_q)) begin
        wdata_q <= link.port_wdata[grant_q];
      end
    end
  end

  // tag store lookup and invalidate; no path to the fast data memory exists
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tag_lookup_q <= 1'b0;
      inval_q <= 1'b0;
    end else begin
      tag_lookup_q <= (state_d == S_DATA);
      inval_q <= (state_q == S_ACK) && write_hit;
    end
  end

  // memory cycle with bounded wait for the acknowledge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_req_q <= 1'b0;
      wait_cnt_q <= '0;
      address_accepted_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      mem_req_q <= (state_d == S_MEM);
      wait_cnt_q <= (state_q == S_MEM) ? wait_cnt_q + 16'h0001 : 16'h0000;
      address_accepted_q <= mem_done;
      timeout_q <= mem_expired;
    end
  end

  // read return: owner queue routes data ready to the issuing port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_rdy_q <= STROBES_RESET;
      mem_data_q <= DATA_RESET;
    end else begin
      data_rdy_q <= (mem_data_valid && fifo_out_valid) ? one_hot(fifo_owner) : STROBES_RESET;
      if (mem_data_valid && fifo_out_valid) begin
        mem_data_q <= mem_rdata;
      end
    end
  end

  owner_fifo #(
    .WIDTH(PORT_ID_W),
    .DEPTH(FIFO_DEPTH)
  ) u_owner_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(mem_done && op_is_read(op_q)),
    .in_ready(fifo_in_ready),
    .in_data(grant_q),
    .out_valid(fifo_out_valid),
    .out_ready(mem_data_valid),
    .out_data(fifo_owner)
  );

  assign link.select_address_strobe = sel_adrs_q;
  assign link.select_data_strobe = sel_data_q;
  assign link.request_accepted = req_ack_q;
  assign link.address_accepted = address_accepted_q;
  assign link.port_timeout = timeout_q;
  assign link.port_data_ready = data_rdy_q;
  assign link.mem_data = mem_data_q;
  assign mem_req = mem_req_q;
  assign mem_write = mem_write_q;
  assign mem_op = op_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign tag_lookup = tag_lookup_q;
  assign tag_index = addr_q[INDEX_MSB:INDEX_LSB];
  assign tag_invalidate = inval_q;
endmodule : storage_port_memory_arbiter
